// ===== rtl/dicl_top.sv
`timescale 1ns/1ps

module dicl_top
  import dicl_pkg::*;
#(
  parameter int unsigned STEP_CYC  = dicl_pkg::UPDN_STEP_CYC,
  parameter int unsigned JOG_CYC   = dicl_pkg::JOG_BOTH_CYC,
  parameter int unsigned FLASH_CY  = dicl_pkg::FLASH_CYC
)(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [7:0]                 adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [31:0]                dat_i,
  output logic      [31:0]                dat_o,
  output logic                            ack_o,
  input  wire logic [dicl_pkg::NUM_TERM-1:0] terminals_i,
  input  wire logic                       run_cmd_i,
  input  wire logic                       motor_stopped_i,
  input  wire logic [dicl_pkg::REF_W-1:0] analog_lower_i,
  output logic      [dicl_pkg::REF_W-1:0] freq_ref_o,
  output logic      [dicl_pkg::REF_W-1:0] bias_o,
  output logic                            run_enable_o,
  output logic                            reverse_o,
  output logic                            jog_active_o,
  output logic                            jog_alarm_o,
  output logic      [1:0]                 time_set_o,
  output logic                            ramp_hold_o,
  output logic                            output_block_o,
  output logic                            output_block_alarm_o,
  output logic                            speed_search_o,
  output logic                            fast_decel_o,
  output logic                            fault_stop_o,
  output logic      [1:0]                 stop_mode_o,
  output logic                            external_fault_indication_o,
  output logic      [2:0]                 fault_terminal_o,
  output logic                            input_assignment_error_o
);
  import dicl_pkg::*;

  function automatic logic [7:0] func_mask(input logic [63:0] tsel, input logic [7:0] code);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      m[i] = (tsel[i*8 +: 8] == code);
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [NUM_TERM-1:0] term_meta;
  logic [NUM_TERM-1:0] term_sync;
  logic                run_meta;
  logic                run_sync;
  logic                stop_meta;
  logic                stop_sync;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      term_meta <= '0;
      term_sync <= '0;
      run_meta  <= 1'b0;
      run_sync  <= 1'b0;
      stop_meta <= 1'b0;
      stop_sync <= 1'b0;
    end
    else
    begin
      term_meta <= terminals_i;
      term_sync <= term_meta;
      run_meta  <= run_cmd_i;
      run_sync  <= run_meta;
      stop_meta <= motor_stopped_i;
      stop_sync <= stop_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and wishbone slave

  logic [31:0]      cfg;
  logic [REF_W-1:0] upper_lim;
  logic [REF_W-1:0] lower_lim;
  logic [REF_W-1:0] jog_freq;
  logic [63:0]      tsel;
  logic             wr_stb;
  logic             fault_clear;
  logic [31:0]      next_dat;

  assign wr_stb      = cyc_i & stb_i & we_i & ~ack_o;
  assign fault_clear = wr_stb & (adr_i == REG_CLEAR) & sel_i[0] & dat_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg       <= CFG_RST;
      upper_lim <= UPPER_RST;
      lower_lim <= LOWER_RST;
      jog_freq  <= JOG_RST;
      tsel      <= {TSEL_RST, TSEL_RST};
    end
    else if (wr_stb)
    begin
      unique case (adr_i)
        REG_CFG:     cfg         <= merge(cfg, dat_i, sel_i);
        REG_UPPER:   upper_lim   <= REF_W'(merge({16'h0000, upper_lim}, dat_i, sel_i));
        REG_LOWER:   lower_lim   <= REF_W'(merge({16'h0000, lower_lim}, dat_i, sel_i));
        REG_JOG:     jog_freq    <= REF_W'(merge({16'h0000, jog_freq}, dat_i, sel_i));
        REG_TSEL_LO: tsel[31:0]  <= merge(tsel[31:0], dat_i, sel_i);
        REG_TSEL_HI: tsel[63:32] <= merge(tsel[63:32], dat_i, sel_i);
        default:     cfg         <= cfg;
      endcase
    end
  end

  logic [REF_W-1:0] updn_ref;
  logic [REF_W-1:0] bias;
  logic [31:0]      status;

  always_comb
  begin
    unique case (adr_i)
      REG_CFG:     next_dat = cfg;
      REG_UPPER:   next_dat = {16'h0000, upper_lim};
      REG_LOWER:   next_dat = {16'h0000, lower_lim};
      REG_JOG:     next_dat = {16'h0000, jog_freq};
      REG_TSEL_LO: next_dat = tsel[31:0];
      REG_TSEL_HI: next_dat = tsel[63:32];
      REG_STATUS:  next_dat = status;
      REG_REF:     next_dat = {16'h0000, updn_ref};
      REG_BIAS:    next_dat = {16'h0000, bias};
      default:     next_dat = 32'h0000_0000;
    endcase
  end

  // one wait state; unmapped reads return zero, writes there are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= (cyc_i & stb_i & ~we_i & ~ack_o) ? next_dat : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal decode

  logic up_in, down_in, up2_in, down2_in, fwd_jog_in, rev_jog_in;
  logic block_req, fs_req, updn_sel, updn_pair_bad;
  logic running;

  assign up_in      = |(func_mask(tsel, FN_UP) & term_sync);
  assign down_in    = |(func_mask(tsel, FN_DOWN) & term_sync);
  assign up2_in     = |(func_mask(tsel, FN_UP2) & term_sync);
  assign down2_in   = |(func_mask(tsel, FN_DOWN2) & term_sync);
  assign fwd_jog_in = |(func_mask(tsel, FN_FWD_JOG) & term_sync);
  assign rev_jog_in = |(func_mask(tsel, FN_REV_JOG) & term_sync) & ~cfg[CFG_REVINH_BIT];
  assign block_req  = |(func_mask(tsel, FN_BLOCK_NO) & term_sync)
                    | |(func_mask(tsel, FN_BLOCK_NC) & ~term_sync);
  assign fs_req     = |(func_mask(tsel, FN_FSTOP_NO) & term_sync)
                    | |(func_mask(tsel, FN_FSTOP_NC) & ~term_sync);
  assign updn_pair_bad = (|func_mask(tsel, FN_UP)) ^ (|func_mask(tsel, FN_DOWN));
  assign updn_sel   = ((cfg[CFG_SRC_SEL_BIT] ? cfg[CFG_SRC2_LSB +: 4] : cfg[CFG_SRC1_LSB +: 4])
                      == SRC_UPDOWN) & ~updn_pair_bad;

  ////////////////////////////////////////////////////////////////////////////
  // up/down reference and bias

  logic [CNT_W-1:0] step_cnt;
  logic             step_tick;
  logic [REF_W-1:0] lower_eff;

  assign step_tick = (step_cnt == CNT_W'(STEP_CYC - 1));
  // analog lower limit only ever lowers the programmed one
  assign lower_eff = (cfg[CFG_ANALOG_LSB +: 4] == ANALOG_LOWER && analog_lower_i < lower_lim)
                   ? analog_lower_i : lower_lim;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || step_tick)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      updn_ref <= '0;
    else if (!cfg[CFG_HOLD_BIT] && !run_sync)
      updn_ref <= '0;
    else if (cfg[CFG_HOLD_BIT] && !run_sync && (up_in || down_in))
      updn_ref <= '0;
    else if (step_tick && updn_sel && run_sync && up_in && !down_in)
      updn_ref <= (updn_ref >= upper_lim) ? upper_lim
                : (updn_ref < lower_eff) ? lower_eff : updn_ref + 1'b1;
    else if (step_tick && updn_sel && run_sync && down_in && !up_in)
      updn_ref <= (updn_ref <= lower_eff) ? lower_eff
                : (updn_ref > upper_lim) ? upper_lim : updn_ref - 1'b1;
  end

  // bias saturates rather than wrapping
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bias <= '0;
    else if (step_tick && up2_in && !down2_in && bias != 16'hFFFF)
      bias <= bias + 1'b1;
    else if (step_tick && down2_in && !up2_in && bias != 16'h0000)
      bias <= bias - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // jog

  logic [CNT_W-1:0] jog_cnt;
  logic             jog_alarm;
  logic             jog_fwd, jog_rev;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !(fwd_jog_in && rev_jog_in))
    begin
      jog_cnt   <= '0;
      jog_alarm <= 1'b0;
    end
    else if (jog_cnt == CNT_W'(JOG_CYC - 1))
      jog_alarm <= 1'b1;
    else
      jog_cnt <= jog_cnt + 1'b1;
  end

  // during the conflict window the earlier direction is not guessed: hold stopped
  assign jog_fwd = fwd_jog_in & ~rev_jog_in;
  assign jog_rev = rev_jog_in & ~fwd_jog_in;
  assign running = run_sync | jog_fwd | jog_rev;

  ////////////////////////////////////////////////////////////////////////////
  // fast stop sequence

  dicl_fs_state_t fs_state;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fs_state <= FS_IDLE;
    else
    begin
      unique case (fs_state)
        FS_IDLE: if (fs_req && running)        fs_state <= FS_STOP;
        FS_STOP: if (stop_sync)                fs_state <= FS_WAIT;
        FS_WAIT: if (!fs_req && !run_sync)     fs_state <= FS_IDLE;
        default:                               fs_state <= FS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external faults

  logic       xf_hit;
  logic [2:0] xf_term;
  logic [1:0] xf_mode;
  logic [7:0] xf_idx;
  logic       fault_flag;
  logic [2:0] fault_term;
  logic [1:0] fault_mode;

  always_comb
  begin
    xf_hit  = 1'b0;
    xf_term = 3'h0;
    xf_mode = STOP_RAMP;
    xf_idx  = 8'h00;
    // downward scan so the lowest terminal wins
    for (int i = NUM_TERM - 1; i >= 0; i--)
    begin
      xf_idx = tsel[i*8 +: 8] - FN_XF_FIRST;
      if (tsel[i*8 +: 8] >= FN_XF_FIRST && tsel[i*8 +: 8] <= FN_XF_LAST
          && (xf_idx[0] ? ~term_sync[i] : term_sync[i])
          && (!xf_idx[1] || running))
      begin
        xf_hit  = 1'b1;
        xf_term = 3'(i);
        xf_mode = xf_idx[3:2];
      end
    end
  end

  // new detection wins over a simultaneous clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fault_flag <= 1'b0;
      fault_term <= 3'h0;
      fault_mode <= STOP_RAMP;
    end
    else if (xf_hit && !fault_flag)
    begin
      fault_flag <= 1'b1;
      fault_term <= xf_term;
      fault_mode <= xf_mode;
    end
    else if (fault_clear && !xf_hit)
      fault_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output block and alarm flash

  logic             block_q;
  logic [CNT_W-1:0] flash_cnt;
  logic             flash;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !block_req)
    begin
      flash_cnt <= '0;
      flash     <= 1'b0;
    end
    else if (flash_cnt == CNT_W'(FLASH_CY - 1))
    begin
      flash_cnt <= '0;
      flash     <= ~flash;
    end
    else
      flash_cnt <= flash_cnt + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic fault_halts;
  assign fault_halts = fault_flag & (fault_mode != STOP_ALARM);
  assign status = {16'h0000, 3'h0, fs_state != FS_IDLE, updn_pair_bad, jog_alarm,
                   block_req, fault_flag, 1'b0, fault_term, fault_mode, running, run_sync};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      block_q                     <= 1'b0;
      freq_ref_o                  <= '0;
      bias_o                      <= '0;
      run_enable_o                <= 1'b0;
      reverse_o                   <= 1'b0;
      jog_active_o                <= 1'b0;
      jog_alarm_o                 <= 1'b0;
      time_set_o                  <= 2'h0;
      ramp_hold_o                 <= 1'b0;
      output_block_o              <= 1'b0;
      output_block_alarm_o        <= 1'b0;
      speed_search_o              <= 1'b0;
      fast_decel_o                <= 1'b0;
      fault_stop_o                <= 1'b0;
      stop_mode_o                 <= STOP_RAMP;
      external_fault_indication_o <= 1'b0;
      fault_terminal_o            <= 3'h0;
      input_assignment_error_o    <= 1'b0;
    end
    else
    begin
      block_q        <= block_req;
      freq_ref_o     <= (jog_fwd || jog_rev) ? jog_freq
                      : updn_sel ? updn_ref : '0;
      bias_o         <= bias;
      run_enable_o   <= (run_sync || jog_fwd || jog_rev) && fs_state == FS_IDLE
                        && !jog_alarm && !fault_halts;
      reverse_o      <= jog_rev;
      jog_active_o   <= jog_fwd | jog_rev;
      // drop with the release so the alarm never overlaps a single jog
      jog_alarm_o    <= jog_alarm & fwd_jog_in & rev_jog_in;
      time_set_o     <= {|(func_mask(tsel, FN_TSEL2) & term_sync),
                         |(func_mask(tsel, FN_TSEL1) & term_sync)};
      ramp_hold_o    <= |(func_mask(tsel, FN_RHOLD) & term_sync);
      output_block_o <= block_req;
      output_block_alarm_o <= block_req & ~flash;
      speed_search_o <= block_q & ~block_req & run_sync;
      fast_decel_o   <= fs_state == FS_STOP
                        || (fault_flag && fault_mode == STOP_FAST);
      fault_stop_o   <= fault_halts;
      stop_mode_o    <= fault_mode;
      external_fault_indication_o <= fault_flag;
      fault_terminal_o <= fault_term;
      input_assignment_error_o <= updn_pair_bad;
    end
  end

endmodule // dicl_top

// ===== rtl/dicl_pkg.sv
package dicl_pkg;

  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  // up/down step period, jog conflict time, alarm flash half period
  localparam int unsigned UPDN_STEP_MS  = 10;
  localparam int unsigned JOG_BOTH_MS   = 500;
  localparam int unsigned FLASH_MS      = 250;
  localparam int unsigned UPDN_STEP_CYC = UPDN_STEP_MS * CYC_PER_MS;
  localparam int unsigned JOG_BOTH_CYC  = JOG_BOTH_MS * CYC_PER_MS;
  localparam int unsigned FLASH_CYC     = FLASH_MS * CYC_PER_MS;
  localparam int unsigned CNT_W         = 27;

  localparam int unsigned NUM_TERM = 8;
  localparam int unsigned REF_W    = 16;

  // register byte offsets
  localparam logic [7:0] REG_CFG     = 8'h00;
  localparam logic [7:0] REG_UPPER   = 8'h04;
  localparam logic [7:0] REG_LOWER   = 8'h08;
  localparam logic [7:0] REG_JOG     = 8'h0C;
  localparam logic [7:0] REG_TSEL_LO = 8'h10;
  localparam logic [7:0] REG_TSEL_HI = 8'h14;
  localparam logic [7:0] REG_STATUS  = 8'h18;
  localparam logic [7:0] REG_REF     = 8'h1C;
  localparam logic [7:0] REG_BIAS    = 8'h20;
  localparam logic [7:0] REG_CLEAR   = 8'h24;

  // configuration fields
  localparam int unsigned CFG_HOLD_BIT    = 0;
  localparam int unsigned CFG_REVINH_BIT  = 1;
  localparam int unsigned CFG_SRC_SEL_BIT = 2;
  localparam int unsigned CFG_SRC1_LSB    = 4;
  localparam int unsigned CFG_SRC2_LSB    = 8;
  localparam int unsigned CFG_ANALOG_LSB  = 12;
  localparam logic [3:0]  SRC_UPDOWN      = 4'h2;
  localparam logic [3:0]  ANALOG_LOWER    = 4'h2;

  localparam logic [31:0]      CFG_RST   = 32'h0000_0000;
  localparam logic [REF_W-1:0] UPPER_RST = 16'hFFFF;
  localparam logic [REF_W-1:0] LOWER_RST = 16'h0000;
  localparam logic [REF_W-1:0] JOG_RST   = 16'h0000;
  localparam logic [31:0]      TSEL_RST  = 32'h0000_0000;

  // terminal function codes
  localparam logic [7:0] FN_UP       = 8'h0A;
  localparam logic [7:0] FN_DOWN     = 8'h0B;
  localparam logic [7:0] FN_UP2      = 8'h0C;
  localparam logic [7:0] FN_DOWN2    = 8'h0D;
  localparam logic [7:0] FN_FWD_JOG  = 8'h0E;
  localparam logic [7:0] FN_REV_JOG  = 8'h0F;
  localparam logic [7:0] FN_TSEL1    = 8'h10;
  localparam logic [7:0] FN_TSEL2    = 8'h11;
  localparam logic [7:0] FN_RHOLD    = 8'h12;
  localparam logic [7:0] FN_BLOCK_NO = 8'h13;
  localparam logic [7:0] FN_BLOCK_NC = 8'h14;
  localparam logic [7:0] FN_FSTOP_NO = 8'h15;
  localparam logic [7:0] FN_FSTOP_NC = 8'h16;
  localparam logic [7:0] FN_XF_FIRST = 8'h17;
  localparam logic [7:0] FN_XF_LAST  = 8'h26;

  // external fault stopping methods
  localparam logic [1:0] STOP_RAMP  = 2'h0;
  localparam logic [1:0] STOP_COAST = 2'h1;
  localparam logic [1:0] STOP_FAST  = 2'h2;
  localparam logic [1:0] STOP_ALARM = 2'h3;

  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_STOP = 3'b010,
    FS_WAIT = 3'b100
  } dicl_fs_state_t;

endpackage

// ===== bench/dicl_checker_assertions.sv
`timescale 1ns/1ps
module dicl_checker
  import dicl_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       run_enable_o,
  input wire logic       reverse_o,
  input wire logic       jog_active_o,
  input wire logic       jog_alarm_o,
  input wire logic       output_block_o,
  input wire logic       output_block_alarm_o,
  input wire logic       speed_search_o,
  input wire logic       fast_decel_o,
  input wire logic       fault_stop_o,
  input wire logic [1:0] stop_mode_o,
  input wire logic       external_fault_indication_o,
  input wire logic [2:0] fault_terminal_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_jog_alarm_halts: assert property (jog_alarm_o |-> !jog_active_o && !run_enable_o) else $error("jog alarm");
  a_rev_needs_jog: assert property (reverse_o |-> jog_active_o) else $error("reverse");
  a_flash_only_blocked: assert property (!output_block_o |-> !output_block_alarm_o) else $error("flash");
  a_flash_starts_high: assert property ($rose(output_block_o) |-> ##[0:1] output_block_alarm_o) else $error("flash");
  a_search_one_pulse: assert property (speed_search_o |->
    ($past(output_block_o) || $past(output_block_o, 2)) ##1 !speed_search_o) else $error("search");
  a_fault_term_held: assert property (external_fault_indication_o && $past(external_fault_indication_o)
    |-> $stable(fault_terminal_o)) else $error("fault terminal");
  a_stop_mode_halt: assert property (fault_stop_o |-> external_fault_indication_o && stop_mode_o != STOP_ALARM)
    else $error("stop mode");
  a_fault_fast_decel: assert property (external_fault_indication_o && stop_mode_o == STOP_FAST
    |-> fast_decel_o && !run_enable_o) else $error("fast stop");
  a_halt_no_run: assert property (fault_stop_o |-> !run_enable_o) else $error("halt");
  c_jog_alarm: cover property (jog_alarm_o);
  c_search: cover property (speed_search_o);
  c_fault_stop: cover property (fault_stop_o);
endmodule // dicl_checker

bind dicl_top dicl_checker i_dicl_checker (.clk_i, .rst_i, .run_enable_o, .reverse_o, .jog_active_o, .jog_alarm_o,
  .output_block_o, .output_block_alarm_o, .speed_search_o, .fast_decel_o, .fault_stop_o, .stop_mode_o,
  .external_fault_indication_o, .fault_terminal_o);

// ===== bench/dicl_switch_model.sv
`timescale 1ns/1ps
module dicl_switch_model #(
  parameter int unsigned STOP_CYC = 12
)(
  input  wire logic       clk_i,
  input  wire logic       run_enable_i,
  output logic [7:0]      terminals_o,
  output logic            run_cmd_o,
  output logic            motor_stopped_o
);
  int unsigned idle_cnt = 0;
  initial
  begin
    terminals_o = 8'h00;
    run_cmd_o = 1'b0;
  end
  // motor coasts down for a while once the drive lets go
  always @(posedge clk_i)
  begin
    if (run_enable_i)
      idle_cnt <= 0;
    else if (idle_cnt < STOP_CYC)
      idle_cnt <= idle_cnt + 1;
  end
  assign motor_stopped_o = (idle_cnt == STOP_CYC);
  task automatic drive(input logic [7:0] t, input logic r);
    terminals_o <= t;
    run_cmd_o <= r;
  endtask
endmodule // dicl_switch_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dicl_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, seen;
  logic [7:0]  adr_i = 8'h00, terminals_i, act;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [15:0] analog_lower_i = 16'h0001, freq_ref_o, bias_o;
  logic        run_cmd_i, motor_stopped_i, run_enable_o, reverse_o, jog_active_o, jog_alarm_o, ramp_hold_o;
  logic        output_block_o, output_block_alarm_o, speed_search_o, fast_decel_o, fault_stop_o;
  logic        external_fault_indication_o, input_assignment_error_o, det;
  logic [1:0]  time_set_o, stop_mode_o, grp;
  logic [2:0]  fault_terminal_o;
  int          errors = 0, num_checks = 0;
  // {terminals, time set, ramp hold, block, jog, reverse}
  localparam logic [13:0] ROWS [9] = '{14'h2000, 14'h2410, 14'h2820, 14'h2C30, 14'h3008,
                                       14'h0004, 14'h2102, 14'h2203, 14'h2300};
  always #2.5 clk_i = ~clk_i;
  dicl_top #(.STEP_CYC(4), .JOG_CYC(20), .FLASH_CY(4)) i_dicl_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .terminals_i, .run_cmd_i, .motor_stopped_i, .analog_lower_i,
    .freq_ref_o, .bias_o, .run_enable_o, .reverse_o, .jog_active_o, .jog_alarm_o, .time_set_o, .ramp_hold_o,
    .output_block_o, .output_block_alarm_o, .speed_search_o, .fast_decel_o, .fault_stop_o, .stop_mode_o,
    .external_fault_indication_o, .fault_terminal_o, .input_assignment_error_o);
  dicl_switch_model i_dicl_switch_model (.clk_i, .run_enable_i(run_enable_o), .terminals_o(terminals_i),
    .run_cmd_o(run_cmd_i), .motor_stopped_o(motor_stopped_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ack is looked at on the edge itself, so release follows that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) errors++;
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic sw(input logic [7:0] t, input logic r, input int n);
    i_dicl_switch_model.drive(t, r);
    tick(n);
  endtask
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100_000;
    errors++;
    end_of_test();
  end
  initial
  begin
    tick(10);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, REG_UPPER, 0); check(rd, 32'h0000FFFF);
    wb(0, 8'h3C, 0); check(rd, 0);
    wb(1, REG_TSEL_LO, 32'h0000000A); tick(4); check(input_assignment_error_o, 1);
    wb(1, REG_TSEL_LO, 32'h0F0E0B0A); wb(1, REG_TSEL_HI, 32'h14121110);
    check(input_assignment_error_o, 0);
    foreach (ROWS[i])
    begin
      sw(ROWS[i][13:6], 1'b0, 5);
      check({time_set_o, ramp_hold_o, output_block_o, jog_active_o, reverse_o}, ROWS[i][5:0]);
    end
    // hold on, analog lower limit below the programmed one
    wb(1, REG_CFG, 32'h2021); wb(1, REG_UPPER, 3); wb(1, REG_LOWER, 2);
    sw(8'h81, 1, 40); check(freq_ref_o, 3);
    sw(8'h82, 1, 40); check(freq_ref_o, 1);
    sw(8'h83, 1, 20); check(freq_ref_o, 1);
    sw(8'h80, 0, 10); check(freq_ref_o, 1);
    sw(8'h81, 0, 10); check(freq_ref_o, 0);
    wb(1, REG_CFG, 32'h2020);
    sw(8'h81, 1, 30); sw(8'h80, 0, 10); check(freq_ref_o, 0);
    wb(1, REG_JOG, 32'h55);
    sw(8'h84, 0, 6); check(freq_ref_o, 16'h0055);
    sw(8'h8C, 0, 30); check({jog_alarm_o, run_enable_o}, 2'b10);
    wb(1, REG_CFG, 32'h2022);
    sw(8'h88, 0, 6); check({jog_active_o, reverse_o}, 0);
    sw(8'h00, 1, 4); check({output_block_o, output_block_alarm_o}, 2'b11);
    seen = 1'b0;
    i_dicl_switch_model.drive(8'h80, 1);
    repeat (8)
    begin
      @(posedge clk_i);
      seen |= speed_search_o;
    end
    check(seen, 1);
    wb(1, REG_TSEL_HI, 32'h14151110);
    sw(8'hC0, 1, 5); check({fast_decel_o, run_enable_o}, 2'b10);
    sw(8'h80, 1, 30); check(run_enable_o, 0);
    sw(8'h80, 0, 5); sw(8'h80, 1, 5); check(run_enable_o, 1);
    for (int c = 23; c <= 38; c++)
    begin
      act = c[0] ? 8'h20 : 8'h00;
      grp = 2'((c - 23) / 4);
      det = ((c - 23) % 4 < 2) || ((c - 23) % 4 == 3);
      sw(act ^ 8'h20, 0, 5);
      wb(1, REG_TSEL_HI, 32'(c) << 8); wb(1, REG_CLEAR, 1);
      // last code of each group is tried while running
      sw(act, ((c - 23) % 4 == 3), 5);
      check({external_fault_indication_o, fault_stop_o}, {det, det && grp != 2'h3});
      if (det) check({stop_mode_o, fault_terminal_o}, {grp, 3'h5});
      sw(act ^ 8'h20, 0, 5);
      wb(1, REG_CLEAR, 1);
    end
    // secondary up/down on terminals 0 and 1 trims the bias
    wb(1, REG_TSEL_LO, 32'h00000D0C);
    sw(8'h21, 0, 40); check(bias_o > 16'h0008, 1);
    sw(8'h22, 0, 60); check(bias_o, 0);
    end_of_test();
  end
endmodule // tb_top
